// [design/mmu_access_fault_check.v]
// Functional notes
// R1: With both write policies, CB 10 is writethrough and 11 is writeback.
// R2: With one policy, C is cache enable and B is write buffer enable.
// R3: AP 00 depends on system and ROM control bits for read rights.
// R4: AP 01, 10, 11 grant fixed rights regardless of control bits.
// R5: Access not allowed by the selected permission raises a permission fault.
// R6: Sixteen domains, each with a 2-bit field in the domain rights word.
// R7: Domain 00 faults, 01 checks permissions, 11 skips them, 10 reserved.
// R8: Fetch aborts are only flagged; data aborts raise a data abort.
// R9: Fault status and address update only on data aborts.
// R10: Data abort loads fault code, domain and faulting virtual address.
// R11: Only highest cause reported: terminal, vector, alignment first.
// R12: Descriptor fetch external abort: 1100 first level, 1110 second level.
// R13: Descriptor type 00 is translation fault: 0101 section, 0111 page.
// R14: Domain fault 1001 section, 1011 page, below translation.
// R15: Permission fault 1101 section, 1111 sub-page, below domain.
// R16: Linefetch external abort 0100 section, 0110 page, below permission.
// R17: Other external abort lowest: 1000 section, 1010 page.
// R18: Domain invalid for terminal, vector, alignment, L1 external, section translation.
// R19: Vector exception for data access to 0x0..0x1f in 26-bit mode.
// R20: Misaligned word or halfword data access faults before permission checks.
// R21: Descriptor domain selects rights; checked at L1 for sections, L2 pages.
// R22: Page permission picked by quarter: 1kB small, 16kB large.
// R23: First-level type 10 is section, 01 is page table pointer.
// R24: Domain number comes from first-level bits 8:5.
// R25: Second-level descriptors carry four sub-page permission fields in 11:4.
// R26: Undefined permission or domain encodings deterministically fault.
// R27: Detected faults suppress the external memory request in that cycle.
`timescale 1ns/1ps
`include "mmu_fault_regs.vh"
module mmu_access_fault_check (
  // Clock and reset
  input wire ref_clk,
  input wire rst_n,
  // Access from the core
  input wire accessValid,
  input wire [31:0] virtAddr,
  input wire isFetch,
  input wire isWrite,
  input wire isSupervisor,
  input wire [1:0] accessSize,
  input wire isLinefetch,
  // Descriptors
  input wire [31:0] firstDesc,
  input wire firstDescValid,
  input wire [31:0] secondDesc,
  input wire secondDescValid,
  // Abort sources outside this block
  input wire terminalExc,
  input wire extAbortL1,
  input wire extAbortL2,
  input wire extAbortMem,
  // Configuration
  input wire mmuEnable,
  input wire alignCheckEn,
  input wire config_32bit,
  input wire [31:0] program_status_word,
  input wire [31:0] domainRights,
  input wire systemCtrlBit,
  input wire romCtrlBit,
  input wire dualCachePolicy,
  // Page attributes
  output reg cacheEnable,
  output reg bufferEnable,
  output reg writeThrough,
  output reg writeBack,
  // Memory request gating
  output wire memRequest,
  // Abort reporting
  output reg dataAbort,
  output reg prefetchAbortFlag,
  output reg [3:0] fault_code,
  output reg [3:0] faultDomain,
  output reg faultDomainValid,
  output reg [31:0] fault_address_reg,
  output reg [7:0] fault_status_reg
);
  wire isPage;
  wire isSection;
  wire l1Invalid;
  wire l2Invalid;
  wire [3:0] domainNum;
  reg [1:0] domainField;
  reg [1:0] cbBits;
  reg [1:0] quarter;
  reg [1:0] pagePerm;
  wire [1:0] accessPermBits;
  wire permAllowed;
  wire checkReady;
  wire vecFault;
  wire alignFault;
  wire domFault;
  wire permFault;
  reg anyFault;
  reg [3:0] code_nxt;
  reg domValid_nxt;
  reg anyFault_r;

  assign isSection = firstDesc[1:0] == `DESC_TYPE_SECTION; // see R23
  assign isPage = firstDesc[1:0] == `DESC_TYPE_COARSE; // see R23
  assign l1Invalid = firstDescValid && firstDesc[1:0] == `DESC_TYPE_FAULT; // see R13
  assign l2Invalid = isPage && secondDescValid && secondDesc[1:0] == `DESC_TYPE_FAULT; // see R13
  assign domainNum = firstDesc[`DOM_HI:`DOM_LO]; // see R24

  // Sixteen 2-bit fields indexed by the descriptor domain
  always @* begin
    domainField = domainRights[{domainNum, 1'b0} +: 2]; // see R6 R21
  end

  // Quarter of the page picks the sub-page permission field
  always @* begin
    quarter = (secondDesc[1:0] == `L2_TYPE_LARGE) ?
      virtAddr[`LARGE_QSEL_HI:`LARGE_QSEL_LO] :
      virtAddr[`SMALL_QSEL_HI:`SMALL_QSEL_LO]; // see R22
    pagePerm = secondDesc[{quarter, 1'b0} + 4'h4 +: 2]; // see R25
  end

  assign accessPermBits = isSection ? firstDesc[`SEC_AP_HI:`SEC_AP_LO] : pagePerm;

  perm_decode uPerm (
    .accessPermBits(accessPermBits),
    .systemCtrlBit(systemCtrlBit),
    .romCtrlBit(romCtrlBit),
    .isSupervisor(isSupervisor),
    .isWrite(isWrite),
    .allowed(permAllowed)
  );

  // Sections check at first level, pages only once the second level is back
  assign checkReady = firstDescValid && (isSection || (isPage && secondDescValid)); // see R21

  assign vecFault = config_32bit && !program_status_word[`PSW_MODE_BIT] && !isFetch &&
    virtAddr <= `VEC_TOP; // see R19
  assign alignFault = alignCheckEn && !isFetch &&
    ((accessSize == `SIZE_WORD && virtAddr[1:0] != 2'h0) ||
     (accessSize == `SIZE_HALF && virtAddr[0])); // see R20
  // Reserved domain value is treated as no access
  assign domFault = checkReady && !l2Invalid &&
    (domainField == `DOM_NOACC || domainField == `DOM_RSVD); // see R7 R26
  // Manager skips the check entirely
  assign permFault = checkReady && !l2Invalid && domainField == `DOM_CLIENT &&
    !permAllowed; // see R5 R7

  // Priority encoder, highest cause first
  always @* begin
    anyFault = 1'b1;
    code_nxt = `FS_EXT_OTHER_SEC;
    domValid_nxt = 1'b1;
    if (terminalExc) begin
      code_nxt = `FS_TERMINAL; // see R11
      domValid_nxt = 1'b0; // see R18
    end else if (vecFault) begin
      code_nxt = `FS_VECTOR; // see R11
      domValid_nxt = 1'b0;
    end else if (alignFault) begin
      code_nxt = `FS_ALIGN; // see R11 R20
      domValid_nxt = 1'b0;
    end else if (!mmuEnable) begin
      // Translation checks are off with the MMU disabled
      anyFault = extAbortMem;
      code_nxt = `FS_EXT_OTHER_SEC;
      domValid_nxt = 1'b0;
    end else if (extAbortL1) begin
      code_nxt = `FS_EXT_L1; // see R12
      domValid_nxt = 1'b0;
    end else if (extAbortL2) begin
      code_nxt = `FS_EXT_L2; // see R12
    end else if (l1Invalid) begin
      code_nxt = `FS_TRANS_SEC; // see R13
      domValid_nxt = 1'b0;
    end else if (l2Invalid) begin
      code_nxt = `FS_TRANS_PAGE; // see R13
    end else if (domFault) begin
      code_nxt = isPage ? `FS_DOM_PAGE : `FS_DOM_SEC; // see R14
    end else if (permFault) begin
      code_nxt = isPage ? `FS_PERM_PAGE : `FS_PERM_SEC; // see R15
    end else if (extAbortMem && isLinefetch) begin
      code_nxt = isPage ? `FS_EXT_LINE_PAGE : `FS_EXT_LINE_SEC; // see R16
    end else if (extAbortMem) begin
      code_nxt = isPage ? `FS_EXT_OTHER_PAGE : `FS_EXT_OTHER_SEC; // see R17
    end else begin
      anyFault = 1'b0;
      domValid_nxt = 1'b0;
    end
    anyFault = anyFault && accessValid;
  end

  // Combinational so a faulting access never reaches memory
  assign memRequest = accessValid && !anyFault &&
    (!mmuEnable || checkReady) && !extAbortMem; // see R27

  // Attribute decode
  always @* begin
    cbBits = isSection ? firstDesc[`CB_HI:`CB_LO] : secondDesc[`CB_HI:`CB_LO];
    cacheEnable = cbBits[1]; // see R2
    bufferEnable = cbBits[0]; // see R2
    writeThrough = dualCachePolicy && cbBits == 2'h2; // see R1
    writeBack = dualCachePolicy && cbBits == 2'h3; // see R1
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataAbort <= 1'b0;
      prefetchAbortFlag <= 1'b0;
      anyFault_r <= 1'b0;
      fault_code <= `FS_VECTOR;
      faultDomain <= `DOM_INVALID;
      faultDomainValid <= 1'b0;
      fault_address_reg <= 32'h00000000;
      fault_status_reg <= 8'h00;
    end else begin
      anyFault_r <= anyFault;
      dataAbort <= anyFault && !isFetch; // see R8
      prefetchAbortFlag <= anyFault && isFetch; // see R8
      // Fetch aborts may be branched around, so the records stay put
      if (anyFault && !isFetch) begin
        fault_code <= code_nxt; // see R9 R10
        faultDomain <= domainNum; // see R10
        faultDomainValid <= domValid_nxt; // see R18
        fault_address_reg <= virtAddr; // see R10
        fault_status_reg <= {domainNum, code_nxt}; // see R10
      end
    end
  end
endmodule

// [design/mmu_fault_regs.vh]
`ifndef MMU_FAULT_REGS_VH
`define MMU_FAULT_REGS_VH
`define DESC_TYPE_FAULT 2'h0
`define DESC_TYPE_COARSE 2'h1
`define DESC_TYPE_SECTION 2'h2
`define L2_TYPE_LARGE 2'h1
`define L2_TYPE_SMALL 2'h2
`define DOM_HI 8
`define DOM_LO 5
`define SEC_AP_HI 11
`define SEC_AP_LO 10
`define CB_HI 3
`define CB_LO 2
`define AP_NONE 2'h0
`define AP_SVC_RW 2'h1
`define AP_USR_RO 2'h2
`define AP_ALL_RW 2'h3
`define DOM_NOACC 2'h0
`define DOM_CLIENT 2'h1
`define DOM_RSVD 2'h2
`define DOM_MANAGER 2'h3
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`define VEC_TOP 32'h0000001F
`define SMALL_QSEL_HI 11
`define SMALL_QSEL_LO 10
`define LARGE_QSEL_HI 15
`define LARGE_QSEL_LO 14
`define FS_TERMINAL 4'h2
`define FS_VECTOR 4'h0
`define FS_ALIGN 4'h1
`define FS_EXT_L1 4'hC
`define FS_EXT_L2 4'hE
`define FS_TRANS_SEC 4'h5
`define FS_TRANS_PAGE 4'h7
`define FS_DOM_SEC 4'h9
`define FS_DOM_PAGE 4'hB
`define FS_PERM_SEC 4'hD
`define FS_PERM_PAGE 4'hF
`define FS_EXT_LINE_SEC 4'h4
`define FS_EXT_LINE_PAGE 4'h6
`define FS_EXT_OTHER_SEC 4'h8
`define FS_EXT_OTHER_PAGE 4'hA
`define DOM_INVALID 4'h0
`define PSW_MODE_BIT 4
`endif

// [design/perm_decode.v]
`timescale 1ns/1ps
`include "mmu_fault_regs.vh"
module perm_decode (
  // Permission selection
  input wire [1:0] accessPermBits,
  input wire systemCtrlBit,
  input wire romCtrlBit,
  // Access kind
  input wire isSupervisor,
  input wire isWrite,
  // Result
  output reg allowed
);
  always @* begin
    allowed = 1'b0;
    case (accessPermBits)
      `AP_NONE: begin
        // Both control bits set is undefined; deny so the outcome is fixed (see R26)
        if (systemCtrlBit && !romCtrlBit) begin
          allowed = isSupervisor && !isWrite; // see R3
        end else if (romCtrlBit && !systemCtrlBit) begin
          allowed = !isWrite; // see R3
        end else begin
          allowed = 1'b0; // see R3
        end
      end
      `AP_SVC_RW: allowed = isSupervisor; // see R4
      `AP_USR_RO: allowed = isSupervisor || !isWrite; // see R4
      `AP_ALL_RW: allowed = 1'b1; // see R4
      default: allowed = 1'b0;
    endcase
  end
endmodule

// [tb/access_chk.sv]
`timescale 1ns/1ps
module access_chk (
  // Clock, reset and access
  input wire ref_clk, rst_n, accessValid, isFetch, terminalExc, alignCheckEn, config_32bit,
  input wire [1:0] accessSize,
  input wire [31:0] virtAddr, program_status_word,
  // Attributes and abort reporting
  input wire dualCachePolicy, cacheEnable, bufferEnable, writeThrough, writeBack, memRequest,
  input wire dataAbort, prefetchAbortFlag,
  input wire [3:0] fault_code, faultDomain,
  input wire [31:0] fault_address_reg,
  input wire [7:0] fault_status_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  term_code_a: assert property (
    accessValid && !isFetch && terminalExc |-> !memRequest ##1 dataAbort && fault_code == 4'h2)
    else $error("terminal abort not reported");
  vector_code_a: assert property (
    accessValid && !isFetch && !terminalExc && config_32bit && !program_status_word[4]
    && virtAddr[31:5] == 27'h0 |=> dataAbort && fault_code == 4'h0)
    else $error("vector abort not reported");
  align_code_a: assert property (
    accessValid && !isFetch && !terminalExc && virtAddr[31:5] != 27'h0 && alignCheckEn
    && accessSize == 2'h2 && virtAddr[1:0] != 2'h0 |-> !memRequest ##1 dataAbort
    && fault_code == 4'h1) else $error("alignment abort not reported");
  fetch_keep_a: assert property (
    accessValid && isFetch |=> $stable(fault_status_reg) && $stable(fault_address_reg)
    && !dataAbort) else $error("fetch touched fault records");
  status_pack_a: assert property (
    dataAbort |-> fault_status_reg == {faultDomain, fault_code})
    else $error("status word mismatch");
  addr_record_a: assert property (
    dataAbort |-> fault_address_reg == $past(virtAddr) && !$past(memRequest))
    else $error("fault address or request gating wrong");
  prefetch_flag_a: assert property (
    prefetchAbortFlag |-> $past(accessValid && isFetch) && !dataAbort)
    else $error("prefetch flag without fetch");
  dual_policy_a: assert property (
    dualCachePolicy && cacheEnable |-> writeThrough == !bufferEnable && writeBack == bufferEnable)
    else $error("write policy decode wrong");
  single_policy_a: assert property (
    !dualCachePolicy |-> !writeThrough && !writeBack) else $error("policy flags in single mode");
  req_gate_a: assert property (
    memRequest |-> accessValid) else $error("request without access");
endmodule
bind mmu_access_fault_check access_chk u_chk (.ref_clk, .rst_n, .accessValid, .isFetch,
  .terminalExc, .alignCheckEn, .config_32bit, .accessSize, .virtAddr, .program_status_word,
  .dualCachePolicy, .cacheEnable, .bufferEnable, .writeThrough, .writeBack, .memRequest,
  .dataAbort, .prefetchAbortFlag, .fault_code, .faultDomain, .fault_address_reg,
  .fault_status_reg);

// [tb/core_model.sv]
`timescale 1ns/1ps
module core_model (
  // Access toward the fault checker
  output logic accessValid, isFetch, isWrite, isSupervisor, isLinefetch,
  output logic [1:0] accessSize,
  output logic [31:0] virtAddr, firstDesc, secondDesc,
  output logic firstDescValid, secondDescValid
);
  initial begin
    {accessValid, isFetch, isWrite, isSupervisor, isLinefetch, accessSize} = 7'h0;
    {virtAddr, firstDesc, secondDesc, firstDescValid, secondDescValid} = 98'h0;
  end
  // ctl is {fetch, write, supervisor, linefetch, size}
  task automatic present(input [31:0] va, d1, d2, input [5:0] ctl);
    {isFetch, isWrite, isSupervisor, isLinefetch, accessSize} = ctl;
    {virtAddr, firstDesc, secondDesc} = {va, d1, d2};
    firstDescValid = 1'b1;
    secondDescValid = (d1[1:0] == 2'h1);
    accessValid = 1'b1;
  endtask
  // Released lines flip so a stale value never looks like a live access
  task automatic idle();
    {accessValid, firstDescValid, secondDescValid} = 3'h0;
    {virtAddr, firstDesc, secondDesc} = ~{virtAddr, firstDesc, secondDesc};
  endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, rst_n, terminalExc, extAbortL1, extAbortL2, extAbortMem, mmuEnable;
  logic alignCheckEn, config_32bit, systemCtrlBit, romCtrlBit, dualCachePolicy;
  logic [31:0] program_status_word, domainRights, d2;
  wire accessValid, isFetch, isWrite, isSupervisor, isLinefetch, firstDescValid, secondDescValid;
  wire cacheEnable, bufferEnable, writeThrough, writeBack, memRequest, dataAbort;
  wire prefetchAbortFlag, faultDomainValid;
  wire [1:0] accessSize;
  wire [3:0] fault_code, faultDomain;
  wire [7:0] fault_status_reg;
  wire [31:0] virtAddr, firstDesc, secondDesc, fault_address_reg;
  int mismatches = 0, checked = 0;
  core_model u_core (.accessValid, .isFetch, .isWrite, .isSupervisor, .isLinefetch,
    .accessSize, .virtAddr, .firstDesc, .secondDesc, .firstDescValid, .secondDescValid);
  mmu_access_fault_check u_dut (.ref_clk, .rst_n, .accessValid, .virtAddr, .isFetch, .isWrite,
    .isSupervisor, .accessSize, .isLinefetch, .firstDesc, .firstDescValid, .secondDesc,
    .secondDescValid, .terminalExc, .extAbortL1, .extAbortL2, .extAbortMem, .mmuEnable,
    .alignCheckEn, .config_32bit, .program_status_word, .domainRights, .systemCtrlBit,
    .romCtrlBit, .dualCachePolicy, .cacheEnable, .bufferEnable, .writeThrough, .writeBack,
    .memRequest, .dataAbort, .prefetchAbortFlag, .fault_code, .faultDomain, .faultDomainValid,
    .fault_address_reg, .fault_status_reg);
  function automatic [31:0] sec(input [1:0] perm, input [3:0] dom, input [1:0] cb);
    sec = {20'h0, perm, 1'b0, dom, 1'b0, cb, 2'h2};
  endfunction
  function automatic [31:0] pt(input [3:0] dom);
    pt = {23'h0, dom, 3'h0, 2'h1};
  endfunction
  // Reference rights table, kept apart from the design's own decoder
  function automatic bit ok(input [1:0] perm, input s, r, w, sup);
    case (perm)
      2'h0: ok = !w && (s ^ r) && (sup || r);
      2'h1: ok = sup;
      2'h2: ok = sup || !w;
      default: ok = 1'b1;
    endcase
  endfunction
  task automatic cmp(input string what, input [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ab is {terminal, first level, second level, memory}
  task automatic go(input [31:0] va, d1, dd, input [5:0] ctl, input [3:0] ab, input flt,
                    input [3:0] code, input dv);
    logic [7:0] old;
    old = fault_status_reg;
    @(posedge ref_clk);
    #1;
    u_core.present(va, d1, dd, ctl);
    {terminalExc, extAbortL1, extAbortL2, extAbortMem} = ab;
    #1;
    cmp("memRequest", !flt, memRequest);
    if (!flt && d1[1:0] == 2'h2) begin
      cmp("cacheBits", d1[3:2], {cacheEnable, bufferEnable});
      cmp("policy", {2{dualCachePolicy & d1[3]}} & {!d1[2], d1[2]}, {writeThrough, writeBack});
    end
    @(posedge ref_clk);
    #1;
    u_core.idle();
    {terminalExc, extAbortL1, extAbortL2, extAbortMem} = 4'h0;
    if (ctl[5]) begin
      cmp("prefetchFlag", flt, prefetchAbortFlag);
      cmp("statusKept", old, fault_status_reg);
    end else begin
      cmp("dataAbort", flt, dataAbort);
      if (flt) begin
        cmp("code", code, fault_code);
        cmp("domValid", dv, faultDomainValid);
        cmp("address", va, fault_address_reg);
        cmp("status", {d1[8:5], code}, fault_status_reg);
      end
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    rst_n = 1'b0;
    {terminalExc, extAbortL1, extAbortL2, extAbortMem, dualCachePolicy} = 5'h0;
    {mmuEnable, alignCheckEn, config_32bit, systemCtrlBit, romCtrlBit} = 5'h1C;
    program_status_word = 32'h00000010;
    domainRights = 32'h00000040;
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    go(32'h111, sec(2'h3, 4'h3, 2'h0), 32'h0, 6'h02, 4'h0, 1'b1, 4'h1, 1'b0);
    go(32'h101, sec(2'h3, 4'h3, 2'h0), 32'h0, 6'h01, 4'h0, 1'b1, 4'h1, 1'b0);
    go(32'h101, sec(2'h3, 4'h3, 2'h0), 32'h0, 6'h00, 4'h0, 1'b0, 4'h0, 1'b0);
    go(32'h111, sec(2'h3, 4'h3, 2'h0), 32'h0, 6'h02, 4'hF, 1'b1, 4'h2, 1'b0);
    go(32'h100, 32'h0, 32'h0, 6'h02, 4'h4, 1'b1, 4'hC, 1'b0);
    go(32'h100, pt(4'h3), 32'hFF2, 6'h02, 4'h2, 1'b1, 4'hE, 1'b1);
    go(32'h100, 32'h60, 32'h0, 6'h02, 4'h1, 1'b1, 4'h5, 1'b0);
    go(32'h100, pt(4'h3), 32'h0, 6'h02, 4'h0, 1'b1, 4'h7, 1'b1);
    go(32'h100, sec(2'h0, 4'h5, 2'h0), 32'h0, 6'h02, 4'h0, 1'b1, 4'h9, 1'b1);
    go(32'h100, pt(4'h5), 32'hFF2, 6'h02, 4'h0, 1'b1, 4'hB, 1'b1);
    go(32'h100, 32'h0, 32'h0, 6'h22, 4'h0, 1'b1, 4'h0, 1'b0);
    go(32'h100, sec(2'h3, 4'h3, 2'h0), 32'h0, 6'h06, 4'h1, 1'b1, 4'h4, 1'b1);
    go(32'h100, pt(4'h3), 32'hFF2, 6'h06, 4'h1, 1'b1, 4'h6, 1'b1);
    go(32'h100, sec(2'h3, 4'h3, 2'h0), 32'h0, 6'h02, 4'h1, 1'b1, 4'h8, 1'b1);
    go(32'h100, pt(4'h3), 32'hFF2, 6'h02, 4'h1, 1'b1, 4'hA, 1'b1);
    go(32'h100, sec(2'h1, 4'h3, 2'h0), 32'h0, 6'h02, 4'h1, 1'b1, 4'hD, 1'b1);
    for (int c = 0; c < 64; c++) begin
      {systemCtrlBit, romCtrlBit} = c[3:2];
      go(32'h100, sec(c[5:4], 4'h3, 2'h0), 32'h0, {1'b0, c[1], c[0], 3'h2}, 4'h0,
         !ok(c[5:4], c[3], c[2], c[1], c[0]), 4'hD, 1'b1);
    end
    for (int i = 0; i < 8; i++) begin
      d2 = {20'h0, ~(8'h03 << (2 * i[1:0])), 2'h0, i[2] ? 2'h1 : 2'h2};
      go(i[1:0] << (i[2] ? 14 : 10), pt(4'h3), d2, 6'h02, 4'h0, 1'b1, 4'hF, 1'b1);
      go((i[1:0] ^ 2'h1) << (i[2] ? 14 : 10), pt(4'h3), d2, 6'h12, 4'h0, 1'b0, 4'h0, 1'b0);
    end
    domainRights = 32'h00000C80;
    go(32'h100, sec(2'h3, 4'h3, 2'h0), 32'h0, 6'h02, 4'h0, 1'b1, 4'h9, 1'b1);
    for (int k = 0; k < 8; k++) begin
      dualCachePolicy = k[2];
      go(32'h100, sec(2'h0, 4'h5, k[1:0]), 32'h0, 6'h12, 4'h0, 1'b0, 4'h0, 1'b0);
    end
    program_status_word = 32'h0;
    go(32'h11, sec(2'h3, 4'h5, 2'h0), 32'h0, 6'h02, 4'h0, 1'b1, 4'h0, 1'b0);
    go(32'h10, sec(2'h3, 4'h5, 2'h0), 32'h0, 6'h22, 4'h0, 1'b0, 4'h0, 1'b0);
    print_verdict();
  end
endmodule
